// ==== rtl/trig_ready_pkg.sv ====
package trig_ready_pkg;
   // Widths
   localparam int CNT_W  = 32;
   localparam int ADDR_W = 8;
   localparam int CTRL_W = 8;
   localparam int EV_W   = 5;
   localparam int STAT_W = 3;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_EXP   = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_OVL   = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_RDO   = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_GAP   = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_FCNT  = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_ISTAT = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_IMASK = 8'h20;

   // Control field positions
   localparam int CB_FRM_HW = 0;
   localparam int CB_ACQ_HW = 1;
   localparam int CB_ROLL   = 2;
   localparam int CB_TWID   = 3;
   localparam int CB_SRC    = 4;

   // Status and event bit positions
   localparam int SB_FWAIT  = 0;
   localparam int SB_AWAIT  = 1;
   localparam int SB_EXPO   = 2;
   localparam int EV_ACQ    = 0;
   localparam int EV_FRM    = 1;
   localparam int EV_EXP    = 2;
   localparam int EV_FOVR   = 3;
   localparam int EV_AOVR   = 4;

   // Pin indices and bus constants
   localparam int PIN_FRM   = 0;
   localparam int PIN_ACQ   = 1;
   localparam int HT_BIT    = 1;
   localparam logic RESP_OKAY = 1'b0;

   // Reset values, counts in clk cycles
   localparam logic [CTRL_W-1:0] RST_CTRL = 8'h00;
   localparam logic [CNT_W-1:0]  RST_EXP  = 32'h0000_03E8;
   localparam logic [CNT_W-1:0]  RST_OVL  = 32'h0000_03E8;
   localparam logic [CNT_W-1:0]  RST_RDO  = 32'h0000_07D0;
   localparam logic [CNT_W-1:0]  RST_GAP  = 32'h0000_0064;
   localparam logic [CNT_W-1:0]  RST_FCNT = 32'h0000_0001;
   localparam logic [CNT_W-1:0]  CNT_ONE  = 32'h0000_0001;

   typedef enum logic [1:0] {
      SRC_OFF = 2'b00,
      SRC_ACQ = 2'b01,
      SRC_FRM = 2'b10
   } src_t;

   typedef enum logic [1:0] {
      S_OFF    = 2'b00,
      S_WAIT   = 2'b01,
      S_EXPOSE = 2'b10,
      S_HOLD   = 2'b11
   } seq_state_t;

   // Count down, stopping at zero
   function automatic logic [CNT_W-1:0] dec_sat(logic [CNT_W-1:0] v);
      return (v != '0) ? v - CNT_ONE : v;
   endfunction : dec_sat
endpackage : trig_ready_pkg

// ==== rtl/seq_if.sv ====
`timescale 1ns/100ps
interface seq_if;
   import trig_ready_pkg::*;
   logic             trig;
   logic             trig_lvl;
   logic             en;
   logic             roll;
   logic             twid;
   logic [CNT_W-1:0] exp_time;
   logic [CNT_W-1:0] ovl_time;
   logic [CNT_W-1:0] rdo_time;
   logic [CNT_W-1:0] gap_time;
   logic             wait_lvl;
   logic             exposing;
   logic             exp_done;

   modport ctl (output trig, trig_lvl, en, roll, twid, exp_time,
                output ovl_time, rdo_time, gap_time,
                input  wait_lvl, exposing, exp_done);
   modport seq (input  trig, trig_lvl, en, roll, twid, exp_time,
                input  ovl_time, rdo_time, gap_time,
                output wait_lvl, exposing, exp_done);
endinterface : seq_if

// ==== rtl/frame_seq.sv ====
`timescale 1ns/100ps
module frame_seq (
   input wire logic clk,
   input wire logic rst_n,
   seq_if.seq       s
);
   import trig_ready_pkg::*;

   seq_state_t       state_ff, nxt_state;
   logic [CNT_W-1:0] exp_cnt_ff, nxt_exp_cnt;
   logic [CNT_W-1:0] rdo_cnt_ff, nxt_rdo_cnt;
   logic [CNT_W-1:0] gap_cnt_ff, nxt_gap_cnt;
   logic             done_ff;

   // Overlap reference: exposure time, or shortest pulse in width mode
   wire logic [CNT_W-1:0] ref_time = s.twid ? s.ovl_time : s.exp_time;
   // Next trigger is safe once its exposure ends after readout does, or once the line gap runs out in rolling mode
   wire logic ready_ok = s.roll ? (gap_cnt_ff == '0)  // [RQ9]
                                : (rdo_cnt_ff <= ref_time); // [RQ7] [RQ8]
   // Exposure ends on pulse fall or when the timer runs out
   wire logic exp_end = (state_ff == S_EXPOSE) &&
                        (s.twid ? !s.trig_lvl : (exp_cnt_ff <= CNT_ONE));

   // Frame trigger sequencing
   always_comb begin
      nxt_state   = state_ff;
      nxt_exp_cnt = dec_sat(exp_cnt_ff);
      nxt_rdo_cnt = dec_sat(rdo_cnt_ff);
      nxt_gap_cnt = dec_sat(gap_cnt_ff);
      case (state_ff)
         S_OFF: begin
            if (s.en) nxt_state = S_WAIT;
         end
         S_WAIT: begin
            if (!s.en) begin
               nxt_state = S_OFF;
            end else if (s.trig) begin
               nxt_state   = S_EXPOSE; // [RQ3]
               nxt_exp_cnt = s.exp_time;
            end
         end
         S_EXPOSE: begin
            if (exp_end) begin
               nxt_state   = S_HOLD;
               nxt_rdo_cnt = s.rdo_time;
               nxt_gap_cnt = s.gap_time;
            end
         end
         S_HOLD: begin
            if (ready_ok) nxt_state = s.en ? S_WAIT : S_OFF; // [RQ4]
         end
         default: nxt_state = S_OFF;
      endcase
   end

   // State and counters
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= S_OFF;
         exp_cnt_ff <= '0;
         rdo_cnt_ff <= '0;
         gap_cnt_ff <= '0;
         done_ff    <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         exp_cnt_ff <= nxt_exp_cnt;
         rdo_cnt_ff <= nxt_rdo_cnt;
         gap_cnt_ff <= nxt_gap_cnt;
         done_ff    <= exp_end;
      end
   end

   // Indicator and exposure outputs
   assign s.wait_lvl = (state_ff == S_WAIT); // [RQ2] [RQ6]
   assign s.exposing = (state_ff == S_EXPOSE);
   assign s.exp_done = done_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_wait_entry: assert property ( // [RQ2]
      (state_ff == S_HOLD) && ready_ok && s.en |=> s.wait_lvl)
      else $error("ready not raised on return to waiting");
   chk_global_timed: assert property ( // [RQ7]
      (state_ff == S_HOLD) && !s.roll && !s.twid &&
      (rdo_cnt_ff > s.exp_time) |=> !s.wait_lvl)
      else $error("ready rose before readout overlap allowed");
   chk_global_width: assert property ( // [RQ8]
      (state_ff == S_HOLD) && !s.roll && s.twid &&
      (rdo_cnt_ff > s.ovl_time) |=> !s.wait_lvl)
      else $error("ready rose before overlap minimum allowed");
   chk_rolling_gap: assert property ( // [RQ9]
      (state_ff == S_HOLD) && s.roll && (gap_cnt_ff != '0)
      |=> !s.wait_lvl)
      else $error("ready rose inside rolling line gap");
   chk_no_skip: assert property ( // [RQ4]
      s.exposing |=> !s.wait_lvl ##1
      ($past(s.exp_done) || !$rose(s.wait_lvl)))
      else $error("ready rose straight out of exposure");
endmodule : frame_seq

// ==== rtl/trig_ready.sv ====
`timescale 1ns/100ps
// Operation
// [RQ1] Output line 1 can carry the acquisition-ready indicator.
// [RQ2] Frame-ready rises whenever waiting for a frame start trigger.
// [RQ3] Frame-ready falls when an accepted frame trigger ends waiting.
// [RQ4] Frame-ready rises again only on re-entering the waiting state.
// [RQ5] Frame trigger while not waiting is dropped; overtrigger flagged.
// [RQ6] Frame-ready exists only with hardware frame triggering on.
// [RQ7] Global timed: rise set by exposure time and readout end.
// [RQ8] Global width: rise set by overlap minimum and readout end.
// [RQ9] Rolling: rise set by first-line exposure end to start gap.
// [RQ10] Output line 1 can carry the frame-ready indicator.
// [RQ11] Source keeps width pulses at least the overlap minimum.
// [RQ12] Source triggers frames only while frame-ready is high.
// [RQ13] Events: acquisition start, frame start, exposure end.
// [RQ14] Acquisition trigger while not waiting dropped; overtrigger.
// [RQ15] Selected indicator is mirrored on line 1 until reselected.
module trig_ready (
   input  wire logic                             clk,
   input  wire logic                             rst_n,
   input  wire logic                             hsel,
   input  wire logic [31:0]                      haddr,
   input  wire logic [1:0]                       htrans,
   input  wire logic                             hwrite,
   input  wire logic [2:0]                       hsize,
   input  wire logic [31:0]                      hwdata,
   input  wire logic                             hready,
   output logic      [31:0]                      hrdata,
   output logic                                  hreadyout,
   output logic                                  hresp,
   input  wire logic                             ext_frame_start_trig,
   input  wire logic                             ext_acq_start_trig,
   output logic                                  line1_out,
   output logic                                  irq,
   output logic      [trig_ready_pkg::STAT_W-1:0] ready_state
);
   import trig_ready_pkg::*;

   seq_if sq ();

   // Pin synchronisers and edge history
   logic [1:0]              meta_ff, sync_ff, prev_ff;
   // Software registers
   logic [CTRL_W-1:0]       ctrl_ff;
   logic [CNT_W-1:0]        exp_ff, ovl_ff, rdo_ff, gap_ff, fcnt_ff;
   logic [EV_W-1:0]         istat_ff, imask_ff;
   logic [EV_W-1:0]         nxt_istat, nxt_imask;
   // Acquisition tracking
   logic                    acq_wait_ff;
   logic [CNT_W-1:0]        frames_left_ff;
   // Bus pipeline
   logic [ADDR_W-1:0]       addr_ff;
   logic                    act_ff, wr_ff;
   logic [31:0]             hrdata_ff, rd_mux;
   logic                    hreadyout_ff, hresp_ff;
   logic                    line1_ff, irq_ff;
   logic [STAT_W-1:0]       stat_ff;

   // Two-stage synchronisers, then edge detection on the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= 2'h0;
         sync_ff <= 2'h0;
         prev_ff <= 2'h0;
      end else begin
         meta_ff <= {ext_acq_start_trig, ext_frame_start_trig};
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   wire logic [1:0] pin_rise = sync_ff & ~prev_ff;

   // Control fields
   wire logic frm_hw_en = ctrl_ff[CB_FRM_HW];
   wire logic acq_hw_en = ctrl_ff[CB_ACQ_HW];
   wire src_t line_src  = src_t'(ctrl_ff[CB_SRC +: 2]);

   // Trigger acceptance and overtrigger detection
   wire logic acq_ready = acq_hw_en & acq_wait_ff;
   wire logic frm_edge  = pin_rise[PIN_FRM] & frm_hw_en;
   wire logic acq_edge  = pin_rise[PIN_ACQ] & acq_hw_en;
   wire logic frame_start_evt   = frm_edge & sq.wait_lvl; // [RQ3]
   wire logic frm_ovr           = frm_edge & ~sq.wait_lvl; // [RQ5]
   wire logic acq_start_evt     = acq_edge & acq_wait_ff;
   wire logic acq_ovr           = acq_edge & ~acq_wait_ff; // [RQ14]
   wire logic exposure_done_evt = sq.exp_done;

   // Sequencer hookup; frame waiting held off while acquisition waits
   assign sq.trig     = frame_start_evt;
   assign sq.trig_lvl = sync_ff[PIN_FRM];
   assign sq.en       = frm_hw_en & ~acq_ready; // [RQ6]
   assign sq.roll     = ctrl_ff[CB_ROLL];
   assign sq.twid     = ctrl_ff[CB_TWID];
   assign sq.exp_time = exp_ff;
   assign sq.ovl_time = ovl_ff;
   assign sq.rdo_time = rdo_ff;
   assign sq.gap_time = gap_ff;

   frame_seq u_seq (
      .clk   (clk),
      .rst_n (rst_n),
      .s     (sq)
   );

   // Acquisition window: wait for start, then run the frame count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acq_wait_ff    <= 1'b1;
         frames_left_ff <= '0;
      end else if (!acq_hw_en) begin
         acq_wait_ff    <= 1'b1;
         frames_left_ff <= '0;
      end else if (acq_start_evt) begin
         acq_wait_ff    <= 1'b0;
         frames_left_ff <= fcnt_ff;
      end else if (exposure_done_evt && !acq_wait_ff) begin
         acq_wait_ff    <= (frames_left_ff <= CNT_ONE);
         frames_left_ff <= dec_sat(frames_left_ff);
      end
   end

   // Address phase capture; reads take one wait state
   wire logic take    = hsel & hready & htrans[HT_BIT];
   wire logic rd_take = take & ~hwrite;
   wire logic wr_go   = act_ff & wr_ff;
   wire logic rd_go   = act_ff & ~wr_ff;

   // Write decode in the data phase
   wire logic wr_ctrl  = wr_go && (addr_ff == OFF_CTRL);
   wire logic wr_exp   = wr_go && (addr_ff == OFF_EXP);
   wire logic wr_ovl   = wr_go && (addr_ff == OFF_OVL);
   wire logic wr_rdo   = wr_go && (addr_ff == OFF_RDO);
   wire logic wr_gap   = wr_go && (addr_ff == OFF_GAP);
   wire logic wr_fcnt  = wr_go && (addr_ff == OFF_FCNT);
   wire logic wr_istat = wr_go && (addr_ff == OFF_ISTAT);
   wire logic wr_imask = wr_go && (addr_ff == OFF_IMASK);

   // Sticky events; a new event wins over a same-cycle clear
   wire logic [EV_W-1:0] ev_set = {acq_ovr, frm_ovr, exposure_done_evt,
                                   frame_start_evt, acq_start_evt}; // [RQ13]
   wire logic [EV_W-1:0] ev_clr = wr_istat ? hwdata[EV_W-1:0] : '0;
   assign nxt_istat = (istat_ff & ~ev_clr) | ev_set; // [RQ5] [RQ14]
   assign nxt_imask = wr_imask ? hwdata[EV_W-1:0] : imask_ff;

   // Read decode; unmapped offsets read zero
   always_comb begin
      rd_mux = '0;
      if (addr_ff == OFF_CTRL) begin
         rd_mux[CTRL_W-1:0] = ctrl_ff;
      end else if (addr_ff == OFF_EXP) begin
         rd_mux = exp_ff;
      end else if (addr_ff == OFF_OVL) begin
         rd_mux = ovl_ff;
      end else if (addr_ff == OFF_RDO) begin
         rd_mux = rdo_ff;
      end else if (addr_ff == OFF_GAP) begin
         rd_mux = gap_ff;
      end else if (addr_ff == OFF_FCNT) begin
         rd_mux = fcnt_ff;
      end else if (addr_ff == OFF_STAT) begin
         rd_mux[STAT_W-1:0] = stat_ff;
      end else if (addr_ff == OFF_ISTAT) begin
         rd_mux[EV_W-1:0] = istat_ff;
      end else if (addr_ff == OFF_IMASK) begin
         rd_mux[EV_W-1:0] = imask_ff;
      end
   end

   // Bus pipeline and response
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_ff      <= '0;
         act_ff       <= 1'b0;
         wr_ff        <= 1'b0;
         hrdata_ff    <= '0;
         hreadyout_ff <= 1'b1;
         hresp_ff     <= RESP_OKAY;
      end else begin
         addr_ff      <= haddr[ADDR_W-1:0];
         act_ff       <= take;
         wr_ff        <= hwrite;
         hreadyout_ff <= ~rd_take;
         hresp_ff     <= RESP_OKAY;
         if (rd_go) hrdata_ff <= rd_mux;
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= RST_CTRL;
         exp_ff  <= RST_EXP;
         ovl_ff  <= RST_OVL;
         rdo_ff  <= RST_RDO;
         gap_ff  <= RST_GAP;
         fcnt_ff <= RST_FCNT;
      end else begin
         if (wr_ctrl) ctrl_ff <= hwdata[CTRL_W-1:0];
         if (wr_exp)  exp_ff  <= hwdata;
         if (wr_ovl)  ovl_ff  <= hwdata;
         if (wr_rdo)  rdo_ff  <= hwdata;
         if (wr_gap)  gap_ff  <= hwdata;
         if (wr_fcnt) fcnt_ff <= hwdata;
      end
   end

   // Line 1 source select mirrors the chosen indicator
   wire logic line_nxt = (line_src == SRC_ACQ) ? acq_ready :   // [RQ1]
                         (line_src == SRC_FRM) ? sq.wait_lvl : // [RQ10]
                         1'b0;

   // Interrupt, status and line outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         istat_ff <= '0;
         imask_ff <= '0;
         irq_ff   <= 1'b0;
         line1_ff <= 1'b0;
         stat_ff  <= '0;
      end else begin
         istat_ff <= nxt_istat;
         imask_ff <= nxt_imask;
         irq_ff   <= |(nxt_istat & nxt_imask);
         line1_ff <= line_nxt; // [RQ15]
         stat_ff  <= {sq.exposing, acq_ready, sq.wait_lvl};
      end
   end

   assign hrdata      = hrdata_ff;
   assign hreadyout   = hreadyout_ff;
   assign hresp       = hresp_ff;
   assign line1_out   = line1_ff;
   assign irq         = irq_ff;
   assign ready_state = stat_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_frame_fall: assert property ( // [RQ3]
      frame_start_evt |=> !sq.wait_lvl ##1 !line1_ff)
      else $error("frame ready did not drop after trigger");
   chk_frame_ovr: assert property ( // [RQ5]
      frm_ovr |=> istat_ff[EV_FOVR] && !$rose(sq.exposing))
      else $error("frame overtrigger not flagged or not ignored");
   chk_acq_ovr: assert property ( // [RQ14]
      acq_ovr |=> istat_ff[EV_AOVR] &&
      (frames_left_ff == ($past(exposure_done_evt) ?
                          dec_sat($past(frames_left_ff)) :
                          $past(frames_left_ff))))
      else $error("acquisition overtrigger not flagged or not ignored");
   chk_ready_gated: assert property ( // [RQ6]
      !frm_hw_en |=> !sq.wait_lvl)
      else $error("frame ready shown with hardware trigger off");
   chk_line_frame: assert property ( // [RQ10] [RQ15]
      (line_src == SRC_FRM) && sq.wait_lvl ##1 (line_src == SRC_FRM)
      |-> line1_ff)
      else $error("line 1 does not mirror frame ready");
   chk_line_acq: assert property ( // [RQ1] [RQ15]
      (line_src == SRC_ACQ) ##1 (line_src == SRC_ACQ)
      |-> line1_ff == $past(acq_ready))
      else $error("line 1 does not mirror acquisition ready");
   chk_exp_event: assert property ( // [RQ13]
      sq.exp_done |=> istat_ff[EV_EXP])
      else $error("exposure end event not recorded");
   chk_irq_level: assert property (
      irq_ff == |(istat_ff & imask_ff))
      else $error("interrupt level disagrees with status and mask");

   // Bus timing, event capture, status mirroring and idle line 1
   chk_read_wait: assert property (
      rd_take |=> !hreadyout_ff ##1 hreadyout_ff)
      else $error("read wait state not inserted exactly once");
   chk_write_nowait: assert property (
      take && hwrite |=> hreadyout_ff)
      else $error("write stalled the bus");
   chk_frame_event: assert property ( // [RQ13]
      frame_start_evt |=> istat_ff[EV_FRM])
      else $error("frame start event not recorded");
   chk_acq_event: assert property ( // [RQ13]
      acq_start_evt |=> istat_ff[EV_ACQ] && !acq_wait_ff)
      else $error("acquisition start not taken or not recorded");
   chk_set_wins: assert property (
      (ev_set != '0) |=> ((istat_ff & $past(ev_set)) == $past(ev_set)))
      else $error("event lost to a same-cycle clear");
   chk_stat_mirror: assert property ( // [RQ2]
      stat_ff == $past({sq.exposing, acq_ready, sq.wait_lvl}))
      else $error("status does not follow the indicators");
   chk_frame_rise: assert property ( // [RQ2]
      $rose(sq.wait_lvl) |=> stat_ff[SB_FWAIT])
      else $error("frame ready rise not shown in status");
   chk_line_off: assert property ( // [RQ15]
      (line_src == SRC_OFF) |=> !line1_ff)
      else $error("line 1 driven with no source chosen");

   cov_frame_taken: cover property (frame_start_evt ##[1:1000]
                                    sq.exp_done);
   cov_frame_ovr:   cover property (frm_ovr);
   cov_acq_taken:   cover property (acq_start_evt ##[1:1000]
                                    frame_start_evt);
   cov_acq_ovr:     cover property (acq_ovr);
   cov_width_done:  cover property (sq.twid && sq.exp_done);
endmodule : trig_ready

// ==== verif/trig_src_model.sv ====
`timescale 1ns/100ps
// Frame start trigger source standing at the far side of the trigger pin
module trig_src_model (
   input  wire logic clk,
   input  wire logic ready,
   output logic      trig
);
   initial trig = 1'b0;

   // Waits for frame ready unless told to overtrigger, then pulses
   task automatic fire(input int dly, input int width, input int min_w,
                       input bit rude);
      int n;
      n = 0;
      repeat (dly) @(posedge clk);
      while (!rude && ready !== 1'b1 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      if (!rude && width < min_w) width = min_w;
      trig <= 1'b1;
      repeat (width) @(posedge clk);
      trig <= 1'b0;
   endtask : fire
endmodule : trig_src_model

// ==== verif/frame_trigger_ready_indicator_tb_top.sv ====
`timescale 1ns/100ps
module frame_trigger_ready_indicator_tb_top;
   import trig_ready_pkg::*;
   localparam logic [31:0] EXP_V = 32'h0000_0005;
   localparam logic [31:0] RDO_V = 32'h0000_000A;
   localparam logic [31:0] OVL_V = 32'h0000_0003;
   localparam logic [31:0] GAP_V = 32'h0000_0003;
   logic              clk, rst_n, hsel, hwrite, hreadyout, hresp;
   logic              acq_trig, frm_trig, line1_out, irq;
   logic [31:0]       haddr, hwdata, hrdata;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [STAT_W-1:0] ready_state;
   int                num_errors, checks_done, cycles;

   trig_ready dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .ext_frame_start_trig(frm_trig),
      .ext_acq_start_trig(acq_trig), .line1_out(line1_out), .irq(irq),
      .ready_state(ready_state));
   trig_src_model src (.clk(clk), .ready(ready_state[SB_FWAIT]),
      .trig(frm_trig));

   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         report_and_stop();
      end
   end

   task report_and_stop;
      if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   task chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One single AHB-Lite transfer, waiting on hready in both phases
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      rd = hrdata;
      chk("bus ready", 32'h1, {31'h0, hreadyout});
   endtask : bus

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr

   task rd_chk(input string what, input logic [7:0] a,
               input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(what, exp, x);
   endtask : rd_chk

   // Counts falling edges until a status bit reaches the level
   task wait_bit(input int b, input logic lvl, output int n);
      n = 0;
      @(negedge clk);
      while (ready_state[b] !== lvl && n < 3000) begin
         @(negedge clk);
         n++;
      end
      chk("wait level", {31'h0, lvl}, {31'h0, ready_state[b]});
   endtask : wait_bit

   task acq_pulse;
      @(posedge clk);
      acq_trig <= 1'b1;
      repeat (2) @(posedge clk);
      acq_trig <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : acq_pulse

   task t_reset;
      chk("line1", 32'h0, {31'h0, line1_out});
      chk("irq", 32'h0, {31'h0, irq});
      chk("hresp", 32'h0, {31'h0, hresp});
      rd_chk("ctrl", OFF_CTRL, {24'h00_0000, RST_CTRL});
      rd_chk("exp", OFF_EXP, RST_EXP);
      rd_chk("rdo", OFF_RDO, RST_RDO);
      rd_chk("stat", OFF_STAT, 32'h0);
      wr(8'h40, 32'hFFFF_FFFF);
      rd_chk("unmapped", 8'h40, 32'h0);
   endtask : t_reset

   task t_ready_line;
      int n;
      wr(OFF_EXP, EXP_V);
      wr(OFF_RDO, RDO_V);
      wr(OFF_OVL, OVL_V);
      wr(OFF_GAP, GAP_V);
      wr(OFF_CTRL, 32'h0000_0021);
      wait_bit(SB_FWAIT, 1'b1, n);
      repeat (2) @(negedge clk);
      chk("line1 frame", 32'h1, {31'h0, line1_out});
      rd_chk("stat wait", OFF_STAT, 32'h1);
      wr(OFF_CTRL, 32'h0000_0001);
      repeat (2) @(negedge clk);
      chk("line1 off", 32'h0, {31'h0, line1_out});
   endtask : t_ready_line

   task t_modes;
      logic [31:0] ctl [3];
      int          wid [3];
      int          lo  [3];
      int          n;
      bit          ok;
      ctl = '{32'h21, 32'h29, 32'h25};
      wid = '{2, 6, 2};
      lo  = '{int'(RDO_V), 6 + int'(RDO_V - OVL_V), int'(EXP_V + GAP_V)};
      for (int i = 0; i < 3; i++) begin
         wr(OFF_CTRL, ctl[i]);
         wr(OFF_ISTAT, 32'h1F);
         wait_bit(SB_FWAIT, 1'b1, n);
         src.fire(0, wid[i], int'(OVL_V), 1'b0);
         wait_bit(SB_FWAIT, 1'b0, n);
         chk("exposing", 32'h4, {29'h0, ready_state});
         @(negedge clk);
         chk("line1 fall", 32'h0, {31'h0, line1_out});
         wait_bit(SB_FWAIT, 1'b1, n);
         n = n + 2;
         ok = (n >= lo[i] - 1) && (n <= lo[i] + 4);
         chk("low time", 32'h1, {31'h0, ok});
         rd_chk("istat frame", OFF_ISTAT, 32'h06);
      end
   endtask : t_modes

   task t_over;
      int n;
      wr(OFF_CTRL, 32'h0000_0021);
      wr(OFF_ISTAT, 32'h1F);
      wr(OFF_IMASK, 32'h08);
      src.fire(0, 1, 0, 1'b0);
      src.fire(2, 1, 0, 1'b1);
      wait_bit(SB_FWAIT, 1'b1, n);
      chk("irq set", 32'h1, {31'h0, irq});
      rd_chk("istat over", OFF_ISTAT, 32'h0E);
      wr(OFF_ISTAT, 32'h08);
      repeat (2) @(negedge clk);
      chk("irq clear", 32'h0, {31'h0, irq});
   endtask : t_over

   task t_disable;
      wr(OFF_CTRL, 32'h0000_0020);
      wr(OFF_ISTAT, 32'h1F);
      repeat (2) @(negedge clk);
      chk("fwait off", 32'h0, {31'h0, ready_state[SB_FWAIT]});
      chk("line1 off", 32'h0, {31'h0, line1_out});
      src.fire(0, 2, 0, 1'b1);
      repeat (10) @(posedge clk);
      rd_chk("istat quiet", OFF_ISTAT, 32'h0);
   endtask : t_disable

   task t_acq;
      int n;
      wr(OFF_CTRL, 32'h0000_0013);
      wr(OFF_ISTAT, 32'h1F);
      wait_bit(SB_AWAIT, 1'b1, n);
      repeat (2) @(negedge clk);
      chk("line1 acq", 32'h1, {31'h0, line1_out});
      acq_pulse();
      acq_pulse();
      @(negedge clk);
      chk("line1 acq low", 32'h0, {31'h0, line1_out});
      rd_chk("istat acq", OFF_ISTAT, 32'h11);
   endtask : t_acq

   // Main sequence
   initial begin
      hsel        = 1'b0;
      haddr       = 32'h0;
      htrans      = 2'b00;
      hwrite      = 1'b0;
      hsize       = 3'b010;
      hwdata      = 32'h0;
      acq_trig    = 1'b0;
      rst_n       = 1'b0;
      num_errors  = 0;
      checks_done = 0;
      cycles      = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_ready_line();
      t_modes();
      t_over();
      t_disable();
      t_acq();
      report_and_stop();
   end
endmodule : frame_trigger_ready_indicator_tb_top
